// ==== dv/anc_source.sv ====
// Upstream ancillary stream source that sends splice messages one byte a clock.
`timescale 1ns/100ps
module anc_source (
  input wire logic pclk,
  output logic anc_valid,
  output logic anc_sop,
  output logic anc_eop,
  output logic [7:0] anc_did,
  output logic [7:0] anc_sdid,
  output logic [7:0] anc_byte,
  output logic [10:0] anc_line,
  output logic anc_chroma,
  output logic anc_field2
);
  // Every packet sits on line 9 of the first field, luma channel.
  assign anc_line = 11'h009;
  assign anc_chroma = 1'b0;
  assign anc_field2 = 1'b0;
  // The stream is quiet until the first packet.
  initial begin
    anc_valid = 1'b0;
    anc_sop = 1'b0;
    anc_eop = 1'b0;
    anc_did = 8'h00;
    anc_sdid = 8'h00;
    anc_byte = 8'h00;
  end
  // The match string is fixed; idle bytes are inverted so stale data never looks valid.
  task automatic send(input logic [7:0] did, input logic [2:0] typ, input logic [15:0] sid,
                      input logic [15:0] pid, input logic [15:0] pre);
    logic [7:0] m [15];
    m = '{{5'h00, typ}, sid[15:8], sid[7:0], pid[15:8], pid[7:0], pre[15:8], pre[7:0],
          8'h03, 8'h31, 8'h32, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 15; i++) begin
      @(posedge pclk);
      anc_valid <= 1'b1;
      anc_sop <= (i == 0);
      anc_eop <= (i == 14);
      anc_did <= did;
      anc_sdid <= splice_dec_pkg::SPLICE_SDID;
      anc_byte <= m[i];
    end
    @(posedge pclk);
    anc_valid <= 1'b0;
    anc_eop <= 1'b0;
    anc_did <= ~did;
    anc_byte <= ~m[14];
  endtask
endmodule

// ==== dv/splice_message_gpio_decoder_tb.sv ====
// Self-checking testbench of the splice message decoder.
`timescale 1ns/100ps
module splice_message_gpio_decoder_tb;
  localparam int unsigned SEC = 40;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gpio_out, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic anc_valid, anc_sop, anc_eop, anc_chroma, anc_field2, dec_valid, rdy, conn;
  logic [7:0] anc_did, anc_sdid, anc_byte, dec_data;
  logic [10:0] anc_line;
  int err_count, checks;
  // The sink is connected and ready except in the sink fault scenarios.
  splice_message_gpio_decoder #(.SEC_CYC(SEC), .MS_CYC_P(4)) splice_message_gpio_decoder_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .anc_valid, .anc_sop, .anc_eop, .anc_did, .anc_sdid, .anc_byte, .anc_line, .anc_chroma,
    .anc_field2, .dec_data, .dec_valid, .dec_ready(rdy), .dec_connected(conn), .gpio_out);
  anc_source anc_source_inst (.pclk, .anc_valid, .anc_sop, .anc_eop, .anc_did, .anc_sdid,
    .anc_byte, .anc_line, .anc_chroma, .anc_field2);
  // Free-running 40 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits up to win cycles for a pulse, then measures how many cycles it stays high.
  task automatic fire(input int win, input logic hit, input int cyc);
    int n;
    int len;
    n = 0;
    len = 0;
    while (gpio_out !== 1'b1 && n < win) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(gpio_out === 1'b1), 32'(hit));
    while (gpio_out === 1'b1 && len < 1000) begin
      @(posedge pclk);
      len++;
    end
    if (hit) chk(32'(len), 32'(cyc));
  endtask
  // A stalled or absent sink loses bytes; polling spans two windows to catch the flag.
  task automatic sink_fault(input logic c, input int bit_no);
    logic seen;
    seen = 1'b0;
    @(posedge pclk);
    conn <= c;
    rdy <= !c;
    anc_source_inst.send(8'h41, 3'h1, 16'h0001, 16'h0002, 16'h0000);
    chk({31'h0, dec_valid}, {31'h0, c});
    if (c) chk({24'h0, dec_data}, 32'h0000_0001);
    for (int i = 0; i < 30; i++) begin
      apb(1'b0, splice_dec_pkg::A_STATUS, 32'h0);
      seen = seen | q[bit_no];
    end
    chk({31'h0, seen}, 32'h0000_0001);
    conn <= 1'b1;
    rdy <= 1'b1;
  endtask
  task automatic summarize();
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hang is cut short well beyond the fewer than two thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
  // Main sequence: reset, register defaults, filters, pre-roll timing, status.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rdy, conn} = 2'b11;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3 * SEC) @(posedge pclk);
    apb(1'b0, splice_dec_pkg::A_CTRL, 32'h0);
    chk(q, 32'h0000_0308);
    apb(1'b0, splice_dec_pkg::A_DELAY, 32'h0);
    chk(q, 32'h0000_0000);
    apb(1'b0, splice_dec_pkg::A_STATUS, 32'h0);
    chk({30'h0, q[1:0]}, 32'h0000_0002);
    apb(1'b0, 8'h2C, 32'h0);
    chk({q[30:0], e}, 32'h0000_0001);
    apb(1'b1, splice_dec_pkg::A_DTMF_LO, 32'h0023_3231);
    apb(1'b1, splice_dec_pkg::A_DTMF_HI, 32'h3000_0000);
    apb(1'b1, splice_dec_pkg::A_CTRL, 32'h0000_0309);
    anc_source_inst.send(8'h41, 3'h0, 16'h0001, 16'h0002, 16'h0000);
    fire(5, 1'b1, SEC);
    anc_source_inst.send(8'h41, 3'h2, 16'h0001, 16'h0002, 16'h0000);
    fire(20, 1'b0, SEC);
    anc_source_inst.send(8'h42, 3'h0, 16'h0001, 16'h0002, 16'h0000);
    fire(20, 1'b0, SEC);
    apb(1'b1, splice_dec_pkg::A_CTRL, 32'h0000_1F0F);
    apb(1'b1, splice_dec_pkg::A_SPLICE_ID, 32'h0000_0005);
    apb(1'b1, splice_dec_pkg::A_PROG_ID, 32'h0000_0006);
    for (int t = 0; t < 5; t++) begin
      anc_source_inst.send(8'h41, 3'(t), 16'h0005, 16'h0006, 16'h0000);
      fire(5, 1'b1, SEC);
    end
    anc_source_inst.send(8'h41, 3'h0, 16'h0004, 16'h0006, 16'h0000);
    fire(20, 1'b0, SEC);
    anc_source_inst.send(8'h41, 3'h0, 16'h0005, 16'h0007, 16'h0000);
    fire(20, 1'b0, SEC);
    apb(1'b1, splice_dec_pkg::A_CTRL, 32'h0000_0309);
    anc_source_inst.send(8'h41, 3'h0, 16'h0004, 16'h0007, 16'h0000);
    fire(5, 1'b1, SEC);
    // A string with a letter in it must be dropped, leaving the old one in force.
    apb(1'b1, splice_dec_pkg::A_DTMF_LO, 32'h0023_3241);
    anc_source_inst.send(8'h41, 3'h0, 16'h0001, 16'h0002, 16'h0000);
    fire(5, 1'b1, SEC);
    apb(1'b1, splice_dec_pkg::A_CTRL, 32'h0000_0308);
    anc_source_inst.send(8'h41, 3'h0, 16'h0001, 16'h0002, 16'h0002);
    fire(5, 1'b0, SEC);
    fire(30, 1'b1, SEC);
    apb(1'b1, splice_dec_pkg::A_DELAY, 32'h0000_FFFE);
    anc_source_inst.send(8'h41, 3'h0, 16'h0001, 16'h0002, 16'h0002);
    fire(5, 1'b1, SEC);
    apb(1'b1, splice_dec_pkg::A_DELAY, 32'h0000_0003);
    anc_source_inst.send(8'h41, 3'h0, 16'h0001, 16'h0002, 16'h0002);
    fire(14, 1'b0, SEC);
    fire(30, 1'b1, SEC);
    sink_fault(1'b1, 7);
    sink_fault(1'b0, 5);
    apb(1'b1, splice_dec_pkg::A_CTRL, 32'h0000_0300);
    repeat (3 * SEC) @(posedge pclk);
    apb(1'b0, splice_dec_pkg::A_STATUS, 32'h0);
    chk(q, 32'h0000_0000);
    summarize();
  end
endmodule

// ==== hdl/ms_countdown.sv ====
// Millisecond down counter that pulses done when the count runs out.
`timescale 1ns/100ps
module ms_countdown #(
  parameter int unsigned MS_CYC_P = splice_dec_pkg::MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [16:0] ms,
  output logic done,
  output logic busy
);
  typedef struct packed {
    logic [splice_dec_pkg::CNT_W-1:0] pre;
    logic [16:0] left;
    logic busy;
    logic done;
  } st_t;
  st_t s_ff, nxt_s;

  // A new start reloads the count, so a later match restarts the wait.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (start) begin
      nxt_s.left = ms;
      nxt_s.pre = '0;
      nxt_s.busy = 1'b1;
    end else if (s_ff.busy) begin
      if (s_ff.left == 17'h0) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end else if (s_ff.pre == splice_dec_pkg::CNT_W'(MS_CYC_P - 1)) begin
        nxt_s.pre = '0;
        nxt_s.left = s_ff.left - 17'h1;
      end else begin
        nxt_s.pre = s_ff.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done = s_ff.done;
  assign busy = s_ff.busy;
endmodule

// ==== hdl/splice_dec_pkg.sv ====
// Shared constants, types and helpers of the splice message decoder.
package splice_dec_pkg;
  // Clock rate and documented times with their cycle counts.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PULSE_S = 1;
  localparam int unsigned PULSE_CYC = PULSE_S * CLK_HZ;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned CNT_W = 26;
  localparam int unsigned FIELD_CAP = 1000;
  localparam int unsigned PCT_FULL = 100;
  // Identifiers of splice insertion packets.
  localparam logic [7:0] SPLICE_DID = 8'h41;
  localparam logic [7:0] SPLICE_SDID = 8'h07;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DTMF_LO = 8'h04;
  localparam logic [7:0] A_DTMF_HI = 8'h08;
  localparam logic [7:0] A_SPLICE_ID = 8'h0C;
  localparam logic [7:0] A_PROG_ID = 8'h10;
  localparam logic [7:0] A_DELAY = 8'h14;
  localparam logic [7:0] A_SVC2 = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_RATE = 8'h20;
  localparam logic [7:0] A_LOC = 8'h24;
  localparam logic [7:0] A_BW = 8'h28;
  // Control field positions and reset values.
  localparam int unsigned B_IGN = 0;
  localparam int unsigned B_FSID = 1;
  localparam int unsigned B_FPID = 2;
  localparam int unsigned B_ALM = 3;
  localparam int unsigned B_TYPE = 8;
  localparam int unsigned B_SVC2 = 16;
  localparam int unsigned B_DLEN = 28;
  localparam logic [31:0] CTRL_RST = 32'h0000_0308;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [3:0] DTMF_MAX = 4'h7;
  // Message byte layout.
  localparam int unsigned M_TYPE = 0;
  localparam int unsigned M_SID = 1;
  localparam int unsigned M_PID = 3;
  localparam int unsigned M_PRE = 5;
  localparam int unsigned M_DLEN = 7;
  localparam int unsigned M_DTMF = 8;
  localparam logic [3:0] M_BYTES = 4'hF;
  // Allowed DTMF characters: the digit range, hash and asterisk.
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_STAR = 8'h2A;
  typedef enum logic [1:0] {GRADE_VALID, GRADE_CAUTION, GRADE_ALARM} grade_t;

  // A zero byte marks an unused character slot.
  function automatic logic char_ok(input logic [7:0] c);
    return c == 8'h00 || (c >= CH_0 && c <= CH_9) || c == CH_HASH || c == CH_STAR;
  endfunction
endpackage

// ==== hdl/splice_message_gpio_decoder.sv ====
// Splice message decoder core: filters, trigger timing, status and APB registers.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - Exact DTMF match plus splice id match gives a one second GPIO pulse.
// - Match string holds at most seven chars: digits, hash or asterisk.
// - Only enabled splice types may produce a GPIO event.
// - Splice id is compared only while its matching is forced.
// - With splice id matching on, unequal ids discard the message.
// - Program id is compared only while its matching is forced.
// - With program id matching on, unequal ids discard the message.
// - Signed millisecond delay shifts pre-roll start; default zero.
// - Ignore pre-roll fires at once, else pre-roll is waited out.
// - Status grades valid, caution, alarm; most severe one is shown.
// - Two enabled services with equal identifiers flag a valid-grade duplicate.
// - No splice packet in input raises caution.
// - Splice data with output port unconnected raises caution.
// - Splice data on both luma and chroma raises caution.
// - Decoded data lost to a slow output port raises caution.
// - Report bytes per second; zero rate alarms when alarm enabled.
// - Report line range, channel and field of decoded data.
// - Cleared alarm enable hides the stream's errors from status.
// - Report per-field ancillary bandwidth use as a percentage.
// - Splice packets are identifier 41 with secondary identifier 07.
module splice_message_gpio_decoder #(
  parameter int unsigned SEC_CYC = splice_dec_pkg::PULSE_CYC,
  parameter int unsigned MS_CYC_P = splice_dec_pkg::MS_CYC,
  parameter int unsigned FIELD_CAP = splice_dec_pkg::FIELD_CAP
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic anc_valid,
  input wire logic anc_sop,
  input wire logic anc_eop,
  input wire logic [7:0] anc_did,
  input wire logic [7:0] anc_sdid,
  input wire logic [7:0] anc_byte,
  input wire logic [10:0] anc_line,
  input wire logic anc_chroma,
  input wire logic anc_field2,
  output logic [7:0] dec_data,
  output logic dec_valid,
  input wire logic dec_ready,
  input wire logic dec_connected,
  output logic gpio_out
);
  localparam int unsigned W = splice_dec_pkg::CNT_W;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dtmf_lo;
    logic [31:0] dtmf_hi;
    logic [15:0] sid;
    logic [15:0] pid;
    logic [15:0] dly;
    logic [15:0] svc2;
    logic rej;
    logic [31:0] rdata;
    logic conn1;
    logic conn2;
    logic dvalid;
    logic [7:0] ddata;
    logic gpio;
    logic [W-1:0] gcnt;
    logic [W-1:0] scnt;
    logic w_seen;
    logic w_luma;
    logic w_chroma;
    logic w_nc;
    logic w_ovf;
    logic [W-1:0] w_bytes;
    logic [10:0] w_lo;
    logic [10:0] w_hi;
    logic w_ch;
    logic w_f2;
    logic [3:0] r_flags;
    logic [W-1:0] r_rate;
    logic [10:0] r_lo;
    logic [10:0] r_hi;
    logic r_ch;
    logic r_f2;
    logic fld_last;
    logic [15:0] fcnt;
    logic [7:0] bw0;
    logic [7:0] bw1;
  } st_t;
  st_t s_ff, nxt_s;

  splice_msg_if msg();
  logic cd_done;
  logic cd_busy;
  logic sel;
  logic win_end;
  logic dtmf_hit;
  logic type_hit;
  logic sid_hit;
  logic pid_hit;
  logic match;
  logic fire;
  logic cd_start;
  logic [16:0] load_ms;
  logic signed [17:0] sum_ms;
  logic dup;
  logic inactive;
  logic [7:0] flags;
  splice_dec_pkg::grade_t grade;
  logic mapped;

  splice_msg_parser u_parse (
    .pclk(pclk),
    .presetn(presetn),
    .anc_valid(anc_valid),
    .anc_sop(anc_sop),
    .anc_eop(anc_eop),
    .anc_did(anc_did),
    .anc_sdid(anc_sdid),
    .anc_byte(anc_byte),
    .msg(msg.src)
  );

  ms_countdown #(.MS_CYC_P(MS_CYC_P)) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .start(cd_start),
    .ms(load_ms),
    .done(cd_done),
    .busy(cd_busy)
  );

  // Only the first len characters take part; lengths must agree too.
  function automatic logic dtmf_eq(input logic [55:0] a, input logic [55:0] b,
                                   input logic [3:0] len);
    logic eq;
    eq = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (4'(i) < len && a[i*8 +: 8] != b[i*8 +: 8]) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction

  // Checks the character slots of a written match word.
  function automatic logic word_ok(input logic [31:0] w, input int unsigned nch);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i < nch && !splice_dec_pkg::char_ok(w[i*8 +: 8])) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Share of the per-field capacity, saturated at full.
  function automatic logic [7:0] pct(input logic [15:0] cnt);
    logic [31:0] p;
    p = (32'(cnt) * splice_dec_pkg::PCT_FULL) / FIELD_CAP;
    return (p > splice_dec_pkg::PCT_FULL) ? 8'(splice_dec_pkg::PCT_FULL) : p[7:0];
  endfunction

  // Message filters: every forced comparison must hold as well.
  assign dtmf_hit = msg.dtmf_len == s_ff.dtmf_hi[splice_dec_pkg::B_DLEN +: 4]
      && dtmf_eq(msg.dtmf, {s_ff.dtmf_hi[23:0], s_ff.dtmf_lo}, msg.dtmf_len);
  assign type_hit = msg.stype <= 3'h4
      && s_ff.ctrl[splice_dec_pkg::B_TYPE + 32'(msg.stype)];
  assign sid_hit = !s_ff.ctrl[splice_dec_pkg::B_FSID] || msg.sid == s_ff.sid;
  assign pid_hit = !s_ff.ctrl[splice_dec_pkg::B_FPID] || msg.pid == s_ff.pid;
  assign match = msg.valid && dtmf_hit && type_hit && sid_hit && pid_hit;

  // Pre-roll plus signed delay, clamped so an early shift fires at once.
  assign sum_ms = $signed({2'b00, msg.preroll_ms}) + 18'($signed(s_ff.dly));
  assign load_ms = sum_ms[17] ? 17'h0 : sum_ms[16:0];
  assign cd_start = match && !s_ff.ctrl[splice_dec_pkg::B_IGN] && load_ms != 17'h0;
  assign fire = (match && !cd_start) || cd_done;

  // Window end and splice packet selection.
  assign win_end = s_ff.scnt == W'(SEC_CYC - 1);
  assign sel = anc_valid && anc_did == splice_dec_pkg::SPLICE_DID
      && anc_sdid == splice_dec_pkg::SPLICE_SDID;

  // Status grading; a cleared alarm enable hides every error.
  assign dup = s_ff.ctrl[splice_dec_pkg::B_SVC2]
      && s_ff.svc2 == {splice_dec_pkg::SPLICE_DID, splice_dec_pkg::SPLICE_SDID};
  assign inactive = s_ff.r_rate == '0;
  always_comb begin
    flags = '0;
    grade = splice_dec_pkg::GRADE_VALID;
    if (s_ff.ctrl[splice_dec_pkg::B_ALM]) begin
      flags = {s_ff.rej, inactive, s_ff.r_flags, dup, 1'b0};
      if (inactive) begin
        grade = splice_dec_pkg::GRADE_ALARM;
      end else if (s_ff.r_flags != 4'h0) begin
        grade = splice_dec_pkg::GRADE_CAUTION;
      end
    end
  end

  assign mapped = paddr <= splice_dec_pkg::A_BW && paddr[1:0] == 2'b00;

  // Next state: registers, output port, trigger pulse and monitors.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.conn1 = dec_connected;
    nxt_s.conn2 = s_ff.conn1;
    if (psel && penable && pwrite) begin
      case (paddr)
        splice_dec_pkg::A_CTRL: begin
          nxt_s.ctrl = pwdata;
        end
        splice_dec_pkg::A_DTMF_LO: begin
          nxt_s.rej = !word_ok(pwdata, 4);
          if (word_ok(pwdata, 4)) begin
            nxt_s.dtmf_lo = pwdata;
          end
        end
        splice_dec_pkg::A_DTMF_HI: begin
          nxt_s.rej = !(word_ok(pwdata, 3) && pwdata[27:24] == 4'h0
              && pwdata[splice_dec_pkg::B_DLEN +: 4] <= splice_dec_pkg::DTMF_MAX);
          if (!nxt_s.rej) begin
            nxt_s.dtmf_hi = pwdata;
          end
        end
        splice_dec_pkg::A_SPLICE_ID: nxt_s.sid = pwdata[15:0];
        splice_dec_pkg::A_PROG_ID: nxt_s.pid = pwdata[15:0];
        splice_dec_pkg::A_DELAY: nxt_s.dly = pwdata[15:0];
        splice_dec_pkg::A_SVC2: nxt_s.svc2 = pwdata[15:0];
        default: nxt_s.ctrl = s_ff.ctrl;
      endcase
    end
    // Read data is captured in the setup phase so it comes from a flop.
    if (psel && !penable) begin
      case (paddr)
        splice_dec_pkg::A_CTRL: nxt_s.rdata = s_ff.ctrl;
        splice_dec_pkg::A_DTMF_LO: nxt_s.rdata = s_ff.dtmf_lo;
        splice_dec_pkg::A_DTMF_HI: nxt_s.rdata = s_ff.dtmf_hi;
        splice_dec_pkg::A_SPLICE_ID: nxt_s.rdata = {16'h0000, s_ff.sid};
        splice_dec_pkg::A_PROG_ID: nxt_s.rdata = {16'h0000, s_ff.pid};
        splice_dec_pkg::A_DELAY: nxt_s.rdata = {16'h0000, s_ff.dly};
        splice_dec_pkg::A_SVC2: nxt_s.rdata = {16'h0000, s_ff.svc2};
        splice_dec_pkg::A_STATUS: nxt_s.rdata = {20'h0, cd_busy, s_ff.gpio, flags, grade};
        splice_dec_pkg::A_RATE: nxt_s.rdata = 32'(s_ff.r_rate);
        splice_dec_pkg::A_LOC: nxt_s.rdata = {8'h00, s_ff.r_f2, s_ff.r_ch,
                                              s_ff.r_hi, s_ff.r_lo};
        splice_dec_pkg::A_BW: nxt_s.rdata = {16'h0000, s_ff.bw1, s_ff.bw0};
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // Retriggerable one second pulse.
    if (fire) begin
      nxt_s.gpio = 1'b1;
      nxt_s.gcnt = W'(SEC_CYC - 1);
    end else if (s_ff.gpio) begin
      if (s_ff.gcnt == '0) begin
        nxt_s.gpio = 1'b0;
      end else begin
        nxt_s.gcnt = s_ff.gcnt - 1'b1;
      end
    end
    // Output port: a byte that finds the holding flop still full is lost.
    if (s_ff.dvalid && dec_ready) begin
      nxt_s.dvalid = 1'b0;
    end
    if (sel) begin
      nxt_s.w_seen = 1'b1;
      nxt_s.w_bytes = s_ff.w_bytes + 1'b1;
      nxt_s.w_luma = s_ff.w_luma || !anc_chroma;
      nxt_s.w_chroma = s_ff.w_chroma || anc_chroma;
      nxt_s.w_lo = (!s_ff.w_seen || anc_line < s_ff.w_lo) ? anc_line : s_ff.w_lo;
      nxt_s.w_hi = (!s_ff.w_seen || anc_line > s_ff.w_hi) ? anc_line : s_ff.w_hi;
      nxt_s.w_ch = anc_chroma;
      nxt_s.w_f2 = anc_field2;
      if (!s_ff.conn2) begin
        nxt_s.w_nc = 1'b1;
      end else if (s_ff.dvalid && !dec_ready) begin
        nxt_s.w_ovf = 1'b1;
      end else begin
        nxt_s.dvalid = 1'b1;
        nxt_s.ddata = anc_byte;
      end
    end
    // One second window: counts become the reported rate and flags.
    if (win_end) begin
      nxt_s.scnt = '0;
      nxt_s.r_rate = s_ff.w_bytes;
      nxt_s.r_flags = {s_ff.w_ovf, s_ff.w_luma && s_ff.w_chroma, s_ff.w_nc,
                       !s_ff.w_seen};
      nxt_s.r_lo = s_ff.w_lo;
      nxt_s.r_hi = s_ff.w_hi;
      nxt_s.r_ch = s_ff.w_ch;
      nxt_s.r_f2 = s_ff.w_f2;
      // A byte on the window's last cycle opens the next window, so no event is lost.
      nxt_s.w_seen = sel;
      nxt_s.w_luma = sel && !anc_chroma;
      nxt_s.w_chroma = sel && anc_chroma;
      nxt_s.w_nc = sel && !s_ff.conn2;
      nxt_s.w_ovf = sel && s_ff.conn2 && s_ff.dvalid && !dec_ready;
      nxt_s.w_bytes = W'(sel);
      nxt_s.w_lo = anc_line;
      nxt_s.w_hi = anc_line;
    end else begin
      nxt_s.scnt = s_ff.scnt + 1'b1;
    end
    // Field bandwidth is settled when the field flag flips.
    if (anc_valid) begin
      if (anc_field2 != s_ff.fld_last) begin
        if (s_ff.fld_last) begin
          nxt_s.bw1 = pct(s_ff.fcnt);
        end else begin
          nxt_s.bw0 = pct(s_ff.fcnt);
        end
        nxt_s.fcnt = 16'h0001;
        nxt_s.fld_last = anc_field2;
      end else if (s_ff.fcnt != 16'hFFFF) begin
        nxt_s.fcnt = s_ff.fcnt + 16'h0001;
      end
    end
  end

  // Reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.ctrl <= splice_dec_pkg::CTRL_RST;
      s_ff.dly <= splice_dec_pkg::DELAY_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Zero wait state slave; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_ff.rdata;
  assign dec_data = s_ff.ddata;
  assign dec_valid = s_ff.dvalid;
  assign gpio_out = s_ff.gpio;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fire_pulse;
    fire |=> gpio_out && s_ff.gcnt == W'(SEC_CYC - 1);
  endproperty
  a_fire_pulse: assert property (p_fire_pulse) else $error("pulse not started");

  property p_dtmf;
    msg.valid && msg.dtmf_len != s_ff.dtmf_hi[splice_dec_pkg::B_DLEN +: 4] |-> !match;
  endproperty
  a_dtmf: assert property (p_dtmf) else $error("dtmf length mismatch matched");

  property p_type;
    msg.valid && !type_hit |-> !match ##1 !cd_busy || $past(cd_busy);
  endproperty
  a_type: assert property (p_type) else $error("disabled type matched");

  property p_sid_free;
    msg.valid && !s_ff.ctrl[splice_dec_pkg::B_FSID] && dtmf_hit && type_hit
        && pid_hit |-> match;
  endproperty
  a_sid_free: assert property (p_sid_free) else $error("free splice id blocked");

  property p_sid;
    msg.valid && s_ff.ctrl[splice_dec_pkg::B_FSID] && msg.sid != s_ff.sid |-> !match;
  endproperty
  a_sid: assert property (p_sid) else $error("splice id mismatch matched");

  property p_pid;
    msg.valid && s_ff.ctrl[splice_dec_pkg::B_FPID] && msg.pid != s_ff.pid |-> !match;
  endproperty
  a_pid: assert property (p_pid) else $error("program id mismatch matched");

  property p_ign;
    match && s_ff.ctrl[splice_dec_pkg::B_IGN] |=> gpio_out;
  endproperty
  a_ign: assert property (p_ign) else $error("immediate trigger late");

  property p_wait;
    match && cd_start && !gpio_out && !cd_busy |=> !gpio_out ##1 !gpio_out;
  endproperty
  a_wait: assert property (p_wait) else $error("pre-roll not waited");

  property p_mask;
    !s_ff.ctrl[splice_dec_pkg::B_ALM] |-> grade == splice_dec_pkg::GRADE_VALID
        && flags == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked stream reports errors");

  property p_sev;
    s_ff.ctrl[splice_dec_pkg::B_ALM] && inactive |-> grade == splice_dec_pkg::GRADE_ALARM;
  endproperty
  a_sev: assert property (p_sev) else $error("alarm not most severe");

  property p_ovf;
    sel && s_ff.conn2 && dec_valid && !dec_ready && !win_end ##1 win_end
        |-> ##1 s_ff.r_flags[3];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not reported");

  property p_noin;
    win_end && !s_ff.w_seen |=> s_ff.r_flags[0];
  endproperty
  a_noin: assert property (p_noin) else $error("no input not flagged");

  property p_did;
    !sel && !dec_valid |=> !dec_valid;
  endproperty
  a_did: assert property (p_did) else $error("foreign packet decoded");

  c_fire: cover property (match ##1 gpio_out);
  c_wait: cover property (cd_start ##[1:20] cd_done);
  c_ovf: cover property (sel && s_ff.conn2 && dec_valid && !dec_ready);
  c_caution: cover property (grade == splice_dec_pkg::GRADE_CAUTION);
endmodule

// ==== hdl/splice_msg_if.sv ====
// Parsed splice message handed from the parser to the decoder core.
`timescale 1ns/100ps
interface splice_msg_if;
  logic valid;
  logic [2:0] stype;
  logic [15:0] sid;
  logic [15:0] pid;
  logic [15:0] preroll_ms;
  logic [3:0] dtmf_len;
  logic [55:0] dtmf;
  modport src(output valid, stype, sid, pid, preroll_ms, dtmf_len, dtmf);
  modport dst(input valid, stype, sid, pid, preroll_ms, dtmf_len, dtmf);
endinterface

// ==== hdl/splice_msg_parser.sv ====
// Collects splice packet payload bytes into one parsed message.
`timescale 1ns/100ps
module splice_msg_parser (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic anc_valid,
  input wire logic anc_sop,
  input wire logic anc_eop,
  input wire logic [7:0] anc_did,
  input wire logic [7:0] anc_sdid,
  input wire logic [7:0] anc_byte,
  splice_msg_if.src msg
);
  typedef struct packed {
    logic [119:0] pay;
    logic [3:0] idx;
    logic vld;
  } st_t;
  st_t s_ff, nxt_s;

  // Short packets are dropped; bytes past the layout are ignored.
  always_comb begin
    logic [3:0] k;
    k = anc_sop ? 4'h0 : s_ff.idx;
    nxt_s = s_ff;
    nxt_s.vld = 1'b0;
    if (anc_valid && anc_did == splice_dec_pkg::SPLICE_DID
        && anc_sdid == splice_dec_pkg::SPLICE_SDID) begin
      if (k < splice_dec_pkg::M_BYTES) begin
        nxt_s.pay[k*8 +: 8] = anc_byte;
        nxt_s.idx = k + 4'h1;
      end
      nxt_s.vld = anc_eop && k >= splice_dec_pkg::M_BYTES - 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Multi-byte fields arrive most significant byte first.
  assign msg.valid = s_ff.vld;
  assign msg.stype = s_ff.pay[splice_dec_pkg::M_TYPE*8 +: 3];
  assign msg.sid = {s_ff.pay[splice_dec_pkg::M_SID*8 +: 8],
                    s_ff.pay[(splice_dec_pkg::M_SID+1)*8 +: 8]};
  assign msg.pid = {s_ff.pay[splice_dec_pkg::M_PID*8 +: 8],
                    s_ff.pay[(splice_dec_pkg::M_PID+1)*8 +: 8]};
  assign msg.preroll_ms = {s_ff.pay[splice_dec_pkg::M_PRE*8 +: 8],
                           s_ff.pay[(splice_dec_pkg::M_PRE+1)*8 +: 8]};
  assign msg.dtmf_len = s_ff.pay[splice_dec_pkg::M_DLEN*8 +: 4];
  assign msg.dtmf = s_ff.pay[splice_dec_pkg::M_DTMF*8 +: 56];
endmodule
